/* File: rtl/ahb_mem_reg_ports.sv */
`include "ahb_ports_defines.svh"
module ahb_mem_reg_ports #(
  parameter int NUM_PORTS = `NUM_PORTS,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic controller_enable_bit,
  input wire logic low_power_bit,
  input wire logic [`CS_W-1:0] write_protect,
  input wire logic reg_sel,
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [1:0] reg_port_transfer_type,
  input wire logic [2:0] reg_size,
  input wire logic reg_port_direction,
  input wire logic [1:0] reg_port_wdata_upper,
  input wire logic [15:0] reg_port_wdata_lower,
  input wire logic reg_ready_in,
  output logic reg_ready_out,
  output logic [1:0] reg_resp,
  output logic [`DATA_W-1:0] reg_rdata,
  output logic reg_wr_strobe,
  output logic reg_rd_strobe,
  output logic [`REG_ADDR_W-1:0] reg_acc_addr,
  output logic [`REG_WD_W-1:0] reg_wr_data,
  input wire logic [`DATA_W-1:0] reg_rd_data,
  input wire logic [NUM_PORTS-1:0][`CS_W-1:0] mem_port_chip_selects,
  input wire logic [NUM_PORTS-1:0] mem_port_global_select,
  input wire logic [NUM_PORTS-1:0][`MEM_ADDR_W-1:0] mem_port_address,
  input wire logic [NUM_PORTS-1:0][1:0] mem_port_transfer_type,
  input wire logic [NUM_PORTS-1:0] mem_port_direction,
  input wire logic [NUM_PORTS-1:0][2:0] mem_port_size,
  input wire logic [NUM_PORTS-1:0][2:0] mem_port_burst_type,
  input wire logic [NUM_PORTS-1:0] mem_port_lock,
  input wire logic [NUM_PORTS-1:0][`DATA_W-1:0] mem_port_write_data,
  input wire logic [NUM_PORTS-1:0] mem_port_ready_in,
  output logic [NUM_PORTS-1:0][`DATA_W-1:0] mem_port_read_data,
  output logic [NUM_PORTS-1:0] mem_port_ready_out,
  output logic [NUM_PORTS-1:0][1:0] mem_port_response,
  output logic mem_cmd_valid,
  input wire logic mem_cmd_ready,
  output logic [76:0] mem_cmd_data,
  input wire logic mem_rsp_valid,
  input wire logic [`DATA_W-1:0] mem_rsp_data
);
  import ahb_ports_pkg::*;

  localparam int HDR_W = `CS_W + 3 + 3 + 1 + `MEM_ADDR_W;
  localparam int CMD_W = 2 + HDR_W + `DATA_W;

  // Register port
  reg_state_e rs_q, rs_d;
  logic r_rdy_q, r_rdy_d;
  logic [1:0] r_resp_q, r_resp_d;
  logic [`DATA_W-1:0] r_rdata_q, r_rdata_d;
  logic r_wr_q, r_wr_d;
  logic r_rd_q, r_rd_d;
  logic [`REG_ADDR_W-1:0] r_addr_q, r_addr_d;
  logic [`REG_WD_W-1:0] r_wd_q, r_wd_d;
  logic r_accept;

  always_comb begin
    rs_d = rs_q;
    r_rdy_d = r_rdy_q;
    r_resp_d = r_resp_q;
    r_rdata_d = r_rdata_q;
    r_wr_d = 1'b0;
    r_rd_d = 1'b0;
    r_addr_d = r_addr_q;
    r_wd_d = r_wd_q;
    // Bit 0 ignored: SEQ equals NONSEQ, BUSY equals IDLE
    r_accept = reg_sel && reg_port_transfer_type[`TRANS_REQ_BIT] && reg_ready_in;
    unique case (rs_q)
      RP_ERR1: begin
        rs_d = RP_ERR2;
        r_rdy_d = 1'b1;
        r_resp_d = `RESP_ERROR;
      end
      RP_READ: begin
        r_rdata_d = reg_rd_data;
        r_rdy_d = 1'b1;
        rs_d = RP_IDLE;
      end
      RP_IDLE, RP_WDATA, RP_ERR2: begin
        if (rs_q == RP_WDATA) begin
          // Only the implemented bits are carried
          r_wd_d = {reg_port_wdata_upper, reg_port_wdata_lower};
          r_wr_d = 1'b1;
        end
        rs_d = RP_IDLE;
        r_rdy_d = 1'b1;
        r_resp_d = `RESP_OKAY;
        if (r_accept) begin
          r_addr_d = reg_addr;
          if (reg_size != `SIZE_WORD) begin
            rs_d = RP_ERR1;
            r_rdy_d = 1'b0;
            r_resp_d = `RESP_ERROR;
          end else if (reg_port_direction) begin
            rs_d = RP_WDATA;
          end else begin
            // One wait state so read data leaves from a flop
            rs_d = RP_READ;
            r_rd_d = 1'b1;
            r_rdy_d = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rs_q <= RP_IDLE;
      r_rdy_q <= 1'b1;
      r_resp_q <= `RESP_OKAY;
      r_rdata_q <= '0;
      r_wr_q <= 1'b0;
      r_rd_q <= 1'b0;
      r_addr_q <= '0;
      r_wd_q <= '0;
    end else begin
      rs_q <= rs_d;
      r_rdy_q <= r_rdy_d;
      r_resp_q <= r_resp_d;
      r_rdata_q <= r_rdata_d;
      r_wr_q <= r_wr_d;
      r_rd_q <= r_rd_d;
      r_addr_q <= r_addr_d;
      r_wd_q <= r_wd_d;
    end
  end

  assign reg_ready_out = r_rdy_q;
  assign reg_resp = r_resp_q;
  assign reg_rdata = r_rdata_q;
  assign reg_wr_strobe = r_wr_q;
  assign reg_rd_strobe = r_rd_q;
  assign reg_acc_addr = r_addr_q;
  assign reg_wr_data = r_wd_q;

  // Memory ports
  logic [NUM_PORTS-1:0] grant;
  logic [NUM_PORTS-1:0] busy;
  logic [NUM_PORTS-1:0] push_req;
  logic [NUM_PORTS-1:0][CMD_W-1:0] push_cmd;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [CMD_W-1:0] fifo_in_data;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    mem_state_e st_q, st_d;
    logic rdy_q, rdy_d;
    logic [1:0] resp_q, resp_d;
    logic [`DATA_W-1:0] rd_q, rd_d;
    logic [HDR_W-1:0] hdr_q, hdr_d;
    logic accept;
    logic bad;

    always_comb begin
      st_d = st_q;
      rdy_d = rdy_q;
      resp_d = resp_q;
      rd_d = rd_q;
      hdr_d = hdr_q;
      // A tied-off port never sees select, so it stays idle
      accept = mem_port_global_select[p] && mem_port_transfer_type[p][`TRANS_REQ_BIT]
               && mem_port_ready_in[p];
      bad = (mem_port_size[p] > `SIZE_WORD)
            || !controller_enable_bit || low_power_bit
            || (mem_port_direction[p] && |(mem_port_chip_selects[p] & write_protect));
      unique case (st_q)
        MP_ERR1: begin
          st_d = MP_ERR2;
          rdy_d = 1'b1;
          resp_d = `RESP_ERROR;
        end
        MP_WAIT: begin
          if (grant[p] && fifo_in_ready) begin
            if (hdr_q[`MEM_ADDR_W]) begin
              st_d = MP_IDLE;
              rdy_d = 1'b1;
            end else begin
              st_d = MP_READ;
            end
          end
        end
        MP_READ: begin
          if (grant[p] && mem_rsp_valid) begin
            rd_d = mem_rsp_data;
            rdy_d = 1'b1;
            st_d = MP_IDLE;
          end
        end
        MP_IDLE, MP_ERR2: begin
          st_d = MP_IDLE;
          rdy_d = 1'b1;
          resp_d = `RESP_OKAY;
          if (accept) begin
            rdy_d = 1'b0;
            if (bad) begin
              // Protected writes are dropped here, never queued
              st_d = MP_ERR1;
              resp_d = `RESP_ERROR;
            end else begin
              st_d = MP_WAIT;
              hdr_d = {mem_port_chip_selects[p], mem_port_burst_type[p], mem_port_size[p],
                       mem_port_direction[p], mem_port_address[p]};
            end
          end
        end
      endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        st_q <= MP_IDLE;
        rdy_q <= 1'b1;
        resp_q <= `RESP_OKAY;
        rd_q <= '0;
        hdr_q <= '0;
      end else begin
        st_q <= st_d;
        rdy_q <= rdy_d;
        resp_q <= resp_d;
        rd_q <= rd_d;
        hdr_q <= hdr_d;
      end
    end

    // Write data is in its data phase while the port waits
    assign push_req[p] = (st_q == MP_WAIT) && grant[p];
    assign push_cmd[p] = {2'(p), hdr_q, mem_port_write_data[p]};
    assign busy[p] = (st_q == MP_WAIT) || (st_q == MP_READ);
    assign mem_port_ready_out[p] = rdy_q;
    assign mem_port_response[p] = resp_q;
    assign mem_port_read_data[p] = rd_q;
  end

  always_comb begin
    fifo_in_valid = |push_req;
    fifo_in_data = '0;
    for (int k = 0; k < NUM_PORTS; k++) begin
      if (push_req[k]) begin
        fifo_in_data = push_cmd[k];
      end
    end
  end

  // Grant is held through a read so the response finds its port
  port_arbiter #(.N(NUM_PORTS)) u_arb (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .req(busy),
    .lock(mem_port_lock),
    .grant(grant)
  );

  // Full FIFO stalls the granted port, which holds ready low
  cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(mem_cmd_valid),
    .out_ready(mem_cmd_ready),
    .out_data(mem_cmd_data)
  );
endmodule // ahb_mem_reg_ports

/* File: rtl/ahb_ports_defines.svh */
`ifndef AHB_PORTS_DEFINES_SVH
`define AHB_PORTS_DEFINES_SVH
// What this block does
// - Register port keeps write-data bits 20:19 and 15:0; others ignored.
// - Direction high means write, low means read, on every port.
// - Four identical memory ports, 0 to 3, each with full signal set.
// - Memory ports never answer RETRY or SPLIT.
// - Each memory port takes a 28-bit byte address.
// - Single transfers and 4, 8, 16 beat incrementing or wrapping bursts.
// - While the granted port holds lock, no other port gets the memory.
// - Incoming ready high ends previous transfer before a new address is taken.
// - Outgoing ready low inserts wait states, high when own transfer ends.
// - Response field carries only OKAY or ERROR, two bits.
// - Memory port errors a transfer larger than its allowed size.
// - Memory port errors a write to a protected region and drops it.
// - Memory port errors any access while disabled or in low power.
// - Register port accepts only word size 0b010; other sizes error.
// - Memory ports accept byte, halfword, word; wider sizes error.
`define TRANS_REQ_BIT 1
`define SIZE_WORD 3'h2
`define RESP_OKAY 2'h0
`define RESP_ERROR 2'h1
`define NUM_PORTS 4
`define MEM_ADDR_W 28
`define CS_W 8
`define DATA_W 32
`define FIFO_DEPTH 32
`define REG_ADDR_W 12
`define REG_WD_W 18
`endif

/* File: rtl/ahb_ports_pkg.sv */
package ahb_ports_pkg;
  typedef enum logic [2:0] {MP_IDLE, MP_WAIT, MP_READ, MP_ERR1, MP_ERR2} mem_state_e;
  typedef enum logic [2:0] {RP_IDLE, RP_WDATA, RP_READ, RP_ERR1, RP_ERR2} reg_state_e;
endpackage

/* File: rtl/cmd_fifo.sv */
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic push, pop;

  // Output stage is its own flop so the memory side sees a clean register
  always_comb begin
    in_ready = cnt_q != (AW+1)'(DEPTH);
    push = in_valid && in_ready;
    pop = (cnt_q != '0) && (!ov_q || out_ready);
    wr_d = push ? wr_q + AW'(1) : wr_q;
    rd_d = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    od_d = pop ? mem_q[rd_q] : od_q;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign out_valid = ov_q;
  assign out_data = od_q;
endmodule // cmd_fifo

/* File: rtl/port_arbiter.sv */
module port_arbiter #(
  parameter int N = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] lock,
  output logic [N-1:0] grant
);
  localparam int IW = $clog2(N);
  logic [N-1:0] grant_q, grant_d;
  logic [IW-1:0] last_q, last_d;
  logic [IW-1:0] idx;

  always_comb begin
    grant_d = grant_q;
    last_d = last_q;
    idx = '0;
    // Owner keeps the memory while busy or locked
    if (!(|(grant_q & (req | lock)))) begin
      grant_d = '0;
      for (int k = 1; k <= N; k++) begin
        idx = IW'((int'(last_q) + k) % N);
        if (req[idx] && grant_d == '0) begin
          grant_d[idx] = 1'b1;
          last_d = idx;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      grant_q <= '0;
      last_q <= '0;
    end else begin
      grant_q <= grant_d;
      last_q <= last_d;
    end
  end

  assign grant = grant_q;
endmodule // port_arbiter

/* File: test/ahb_mem_reg_ports_tb_top.sv */
module ahb_mem_reg_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, nrst = 1'b0, controller_enable_bit = 1'b1, low_power_bit = 1'b0;
  logic reg_sel = 1'b0, reg_port_direction = 1'b0, stall = 1'b0;
  logic reg_ready_out, reg_wr_strobe, reg_rd_strobe, mem_cmd_valid, mem_cmd_ready, mem_rsp_valid;
  logic [7:0] write_protect = 8'h80;
  logic [11:0] reg_addr = 12'h0, reg_acc_addr;
  logic [1:0] reg_port_transfer_type = 2'h0, reg_port_wdata_upper = 2'h0, reg_resp, st;
  logic [2:0] reg_size = 3'h2;
  logic [15:0] reg_port_wdata_lower = 16'h0;
  logic [17:0] reg_wr_data, wseen;
  logic [31:0] reg_rdata, reg_rd_data = 32'h5a5ac3c3, mem_rsp_data;
  // Unused ports idle at 0 between transfers
  logic [3:0][7:0] mem_port_chip_selects = '0;
  logic [3:0] mem_port_global_select = '0, mem_port_direction = '0, mem_port_lock = '0;
  logic [3:0] mem_port_ready_out;
  logic [3:0][27:0] mem_port_address = '0;
  logic [3:0][1:0] mem_port_transfer_type = '0, mem_port_response;
  logic [3:0][2:0] mem_port_size = '0, mem_port_burst_type = '0;
  logic [3:0][31:0] mem_port_write_data = '0, mem_port_read_data;
  logic [76:0] mem_cmd_data, last_cmd;
  wire reg_ready_in = reg_ready_out;
  wire [3:0] mem_port_ready_in = mem_port_ready_out;
  int errors = 0, comparisons = 0, ncmd = 0;
  ahb_mem_reg_ports #(.FIFO_DEPTH(4)) ahb_mem_reg_ports_i (.*);
  mem_side_model mem_side_model_i (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (reg_wr_strobe) wseen <= reg_wr_data;
    st <= st | {reg_wr_strobe, reg_rd_strobe};
    if (mem_cmd_valid && mem_cmd_ready) ncmd <= ncmd + 1;
    if (mem_cmd_valid && mem_cmd_ready) last_cmd <= mem_cmd_data;
  end
  task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic reg_xfer(logic wr, logic [1:0] tt, logic [2:0] sz, logic [17:0] wd,
      output logic [1:0] rsp, output logic [31:0] rd);
    reg_sel = 1'b1;
    reg_port_transfer_type = tt;
    reg_size = sz;
    reg_port_direction = wr;
    reg_addr = wd[11:0];
    st = 2'h0;
    @(negedge sys_clk);
    reg_sel = 1'b0;
    reg_port_transfer_type = 2'h0;
    {reg_port_wdata_upper, reg_port_wdata_lower} = wd;
    for (int n = 0; n < 50 && !reg_ready_out; n++) @(negedge sys_clk);
    rsp = reg_resp;
    rd = reg_rdata;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic mem_xfer(int p, logic wr, logic [2:0] sz, logic [2:0] bt, logic [27:0] a,
      output logic [1:0] rsp, output logic [31:0] rd, output logic ok);
    mem_port_global_select[p] = 1'b1;
    mem_port_chip_selects[p] = 8'h01 << a[27:25];
    mem_port_transfer_type[p] = 2'h2;
    mem_port_direction[p] = wr;
    mem_port_size[p] = sz;
    mem_port_burst_type[p] = bt;
    mem_port_address[p] = a;
    @(negedge sys_clk);
    mem_port_global_select[p] = 1'b0;
    mem_port_chip_selects[p] = 8'h00;
    mem_port_transfer_type[p] = 2'h0;
    mem_port_write_data[p] = ~{4'h0, a};
    for (int n = 0; n < 40 && !mem_port_ready_out[p]; n++) @(negedge sys_clk);
    ok = mem_port_ready_out[p];
    rsp = mem_port_response[p];
    rd = mem_port_read_data[p];
    @(negedge sys_clk);
  endtask
  task automatic t_reg();
    logic [1:0] rsp;
    logic [31:0] rd;
    reg_xfer(1'b1, 2'h2, 3'h2, 18'h2a5c3, rsp, rd);
    check("reg write", {st, wseen, reg_acc_addr}, {2'h2, 18'h2a5c3, 12'h5c3});
    reg_xfer(1'b1, 2'h3, 3'h2, 18'h1f00f, rsp, rd);
    check("reg write seq", {st, rsp, wseen}, {2'h2, 2'h0, 18'h1f00f});
    reg_xfer(1'b0, 2'h2, 3'h2, 18'h00010, rsp, rd);
    check("reg read", {st, rsp, rd}, {2'h1, 2'h0, 32'h5a5ac3c3});
    for (int t = 0; t < 2; t++) begin
      reg_xfer(t[0], t[1:0], 3'h2, 18'h3ffff, rsp, rd);
      check("reg idle busy", st, 2'h0);
    end
    for (int s = 0; s < 8; s++) begin
      if (s == 2) continue;
      reg_xfer(s[0], 2'h2, s[2:0], 18'h0, rsp, rd);
      check("reg bad size", {st, rsp}, {2'h0, 2'h1});
    end
  endtask
  task automatic t_mem();
    logic [1:0] rsp;
    logic [31:0] rd;
    logic ok;
    logic [27:0] a;
    logic [2:0] sz;
    // Two burst codes on each port covers every code once
    for (int i = 0; i < 8; i++) begin
      a = 28'(28'h0123450 + 28'h0100000 * i);
      sz = 3'(i % 3);
      mem_xfer(i % 4, 1'b1, sz, i[2:0], a, rsp, rd, ok);
      repeat (4) @(negedge sys_clk);
      check("mem write", {ok, rsp, last_cmd[31:0]}, {1'b1, 2'h0, ~{4'h0, a}});
      check("mem cmd", {last_cmd[76:75], last_cmd[66:32]}, {i[1:0], i[2:0], sz, 1'b1, a});
      mem_xfer(i % 4, 1'b0, sz, i[2:0], a, rsp, rd, ok);
      check("mem read", {ok, rsp, rd}, {1'b1, 2'h0, 4'h0, a});
    end
  endtask
  task automatic t_err();
    logic [1:0] rsp;
    logic [31:0] rd;
    logic ok;
    int n0;
    for (int c = 0; c < 4; c++) begin
      controller_enable_bit = (c != 1);
      low_power_bit = (c == 2);
      n0 = ncmd;
      mem_xfer(0, c != 0, c == 0 ? 3'h3 : 3'h2, 3'h0, c == 3 ? 28'he000010 : 28'h10, rsp, rd, ok);
      repeat (4) @(negedge sys_clk);
      check("mem error", {ok, rsp, 28'(ncmd - n0)}, {1'b1, 2'h1, 28'h0});
    end
    controller_enable_bit = 1'b1;
    low_power_bit = 1'b0;
  endtask
  task automatic t_lock_fifo();
    logic [1:0] rsp;
    logic [31:0] rd;
    logic ok;
    int n0, n1;
    mem_port_lock[1] = 1'b1;
    mem_xfer(1, 1'b0, 3'h2, 3'h0, 28'h40, rsp, rd, ok);
    mem_xfer(0, 1'b1, 3'h2, 3'h0, 28'h44, rsp, rd, ok);
    check("locked out", ok, 1'b0);
    mem_port_lock[1] = 1'b0;
    for (int n = 0; n < 40 && !mem_port_ready_out[0]; n++) @(negedge sys_clk);
    check("after unlock", mem_port_ready_out[0], 1'b1);
    @(negedge sys_clk);
    stall = 1'b1;
    n0 = 0;
    ok = 1'b1;
    while (ok && n0 < 10) begin
      mem_xfer(2, 1'b1, 3'h2, 3'h0, 28'h100 + 4 * n0, rsp, rd, ok);
      n0 += ok;
    end
    check("fifo refuses", n0 >= 4 && n0 < 10, 1'b1);
    n1 = ncmd;
    stall = 1'b0;
    repeat (30) @(negedge sys_clk);
    // Port 0 command held at the output plus the refused write
    check("fifo drained", ncmd - n1, n0 + 2);
  endtask
  initial begin
    #800000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    t_reg();
    t_mem();
    t_err();
    t_lock_fifo();
    give_verdict();
  end
endmodule // ahb_mem_reg_ports_tb_top

/* File: test/ahb_ports_properties.sv */
module ahb_ports_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic controller_enable_bit,
  input wire logic low_power_bit,
  input wire logic [7:0] write_protect,
  input wire logic reg_sel,
  input wire logic [1:0] reg_port_transfer_type,
  input wire logic [2:0] reg_size,
  input wire logic reg_port_direction,
  input wire logic [1:0] reg_port_wdata_upper,
  input wire logic [15:0] reg_port_wdata_lower,
  input wire logic reg_ready_in,
  input wire logic reg_ready_out,
  input wire logic [1:0] reg_resp,
  input wire logic reg_wr_strobe,
  input wire logic reg_rd_strobe,
  input wire logic [17:0] reg_wr_data,
  input wire logic [3:0][7:0] mem_port_chip_selects,
  input wire logic [3:0] mem_port_global_select,
  input wire logic [3:0][1:0] mem_port_transfer_type,
  input wire logic [3:0] mem_port_direction,
  input wire logic [3:0][2:0] mem_port_size,
  input wire logic [3:0] mem_port_ready_in,
  input wire logic [3:0] mem_port_ready_out,
  input wire logic [3:0][1:0] mem_port_response
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic rq, mq, bad;
  logic [3:0][1:0] mr;
  logic [17:0] wd;
  assign mr = mem_port_response;
  assign wd = {reg_port_wdata_upper, reg_port_wdata_lower};
  assign rq = reg_sel && reg_port_transfer_type[1] && reg_ready_in && reg_ready_out;
  assign mq = mem_port_global_select[0] && mem_port_transfer_type[0][1] && mem_port_ready_in[0]
      && mem_port_ready_out[0];
  assign bad = !controller_enable_bit || low_power_bit || mem_port_size[0] > 3'h2
      || (mem_port_direction[0] && |(mem_port_chip_selects[0] & write_protect));
  a_no_retry_split: assert property (!(reg_resp[1] || mr[0][1] || mr[1][1]
      || mr[2][1] || mr[3][1])) else $error("Response outside OKAY and ERROR");
  a_mem_err_pair: assert property (mr[0] == 2'h1 && !mem_port_ready_out[0] |=>
      mr[0] == 2'h1 && mem_port_ready_out[0]) else $error("Memory error not two cycles");
  a_reg_err_pair: assert property (reg_resp == 2'h1 && !reg_ready_out |=>
      reg_resp == 2'h1 && reg_ready_out) else $error("Register error not two cycles");
  a_reg_size_err: assert property (rq && reg_size != 3'h2 |=> !reg_ready_out
      && reg_resp == 2'h1 && !reg_rd_strobe ##1 !reg_wr_strobe)
    else $error("Register size not refused");
  a_reg_wr_data: assert property (rq && reg_size == 3'h2 && reg_port_direction |=> ##1
      reg_wr_strobe && reg_wr_data == $past(wd))
    else $error("Register write data wrong");
  a_reg_rd_wait: assert property (rq && reg_size == 3'h2 && !reg_port_direction |=>
      !reg_ready_out && reg_rd_strobe ##1 reg_ready_out) else $error("Register read timing");
  a_mem_err_cause: assert property (mq && bad |=>
      mr[0] == 2'h1 && !mem_port_ready_out[0]) else $error("Memory error missing");
  a_mem_wait_state: assert property (mq && !bad && !mem_port_direction[0] |=>
      !mem_port_ready_out[0] && mr[0] == 2'h0) else $error("Memory read wait missing");
  c_reg_err: cover property (rq && reg_size != 3'h2);
  c_mem_err: cover property (mq && bad);
  c_mem_stall: cover property (!mem_port_ready_out[0] [*8]);
endmodule // ahb_ports_checker
bind ahb_mem_reg_ports ahb_ports_checker ahb_ports_checker_i (.*);

/* File: test/mem_side_model.sv */
module mem_side_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic mem_cmd_valid,
  output logic mem_cmd_ready,
  input wire logic [76:0] mem_cmd_data,
  output logic mem_rsp_valid,
  output logic [31:0] mem_rsp_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take_rd;
  assign mem_cmd_ready = !stall;
  assign take_rd = mem_cmd_valid && mem_cmd_ready && !mem_cmd_data[60];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= 32'h0;
    end else begin
      mem_rsp_valid <= take_rd;
      // Idle data flips so stale reads never match
      mem_rsp_data <= take_rd ? {4'h0, mem_cmd_data[59:32]} : ~mem_rsp_data;
    end
  end
endmodule // mem_side_model
